// ==== src/rrs_pkg.sv ====
// Purpose: Shared constants and types for the reference changeover switch
// Assumes: One system clock at 40 MHz
// Notes:   Register map reached over the plain strobe port
package rrs_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [3:0] RRS_OFF_CTRL   = 4'h0;
   localparam logic [3:0] RRS_OFF_CFG    = 4'h1;
   localparam logic [3:0] RRS_OFF_STATUS = 4'h2;
   localparam logic [3:0] RRS_OFF_IRQ    = 4'h3;
   localparam logic [3:0] RRS_OFF_MASK   = 4'h4;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int RRS_CTRL_AUTO    = 0;
   localparam int RRS_CTRL_UNIT    = 1;
   localparam int RRS_CFG_KEEP     = 0;
   localparam int RRS_CFG_FPLOCK   = 1;
   localparam int RRS_CFG_REMLOCK  = 2;
   localparam int RRS_CFG_LANFUNC  = 3;
   localparam int RRS_CFG_PRIO_EN  = 4;
   localparam int RRS_CFG_PRIO_SEL = 5;
   localparam int RRS_CFG_FIRSTSYN = 6;
   localparam int RRS_IRQ_SWITCH   = 0;
   localparam int RRS_IRQ_BOTHLOST = 1;
   localparam int RRS_IRQ_REGAIN   = 2;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [1:0] RRS_CTRL_RST = 2'h1;
   localparam logic [6:0] RRS_CFG_RST  = 7'h00;
   localparam logic [2:0] RRS_IRQ_RST  = 3'h0;

   typedef enum logic [1:0] {
      RRS_ST_IDLE,
      RRS_ST_AUTO,
      RRS_ST_MANUAL,
      RRS_ST_HOLD
   } rrs_state_t;

   typedef struct packed {
      logic pps;
      logic freq;
      logic tc_dcls;
      logic tc_am;
   } rrs_sig_t;

   typedef struct packed {
      logic keep;
      logic fp_lock;
      logic rem_lock;
      logic lan_func;
      logic prio_en;
      logic prio_sel;
      logic first_sync;
   } rrs_cfg_t;

endpackage : rrs_pkg

// ==== src/rrs_sync2.sv ====
// Purpose: Two-flop level synchroniser
// Assumes: Slow level inputs
// Notes:   First stage read only by second
`timescale 1ns/100ps
module rrs_sync2 (
   input  wire logic clk_sys_i,
   input  wire logic rstn_i,
   input  wire logic d_i,
   output logic      q_o
);
   logic meta;

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta <= 1'b0;
         q_o  <= 1'b0;
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule : rrs_sync2

// ==== src/rrs_selector.sv ====
// Purpose: Chooses active reference unit each cycle
// Assumes: Flags already synchronised
// Notes:   Pure next-state logic; the caller registers it
`timescale 1ns/100ps
module rrs_selector (
   input  wire logic            auto_i,
   input  wire logic            manual_unit_i,
   input  wire logic            sync_a_i,
   input  wire logic            sync_b_i,
   input  wire logic            cur_sel_i,
   input  wire rrs_pkg::rrs_cfg_t cfg_i,
   output logic                 next_sel_o
);
   logic master_ok;
   logic backup_ok;
   logic prio_unit;

   always_comb begin
      master_ok  = cur_sel_i ? sync_b_i : sync_a_i;
      backup_ok  = cur_sel_i ? sync_a_i : sync_b_i;
      prio_unit  = ~cfg_i.prio_sel;
      next_sel_o = cur_sel_i;
      if (!auto_i) begin
         next_sel_o = manual_unit_i;
      end else if (cfg_i.prio_en && ((prio_unit ? sync_b_i : sync_a_i) || !master_ok)) begin
         if (prio_unit ? sync_b_i : sync_a_i)
            next_sel_o = prio_unit;
         else if (backup_ok)
            next_sel_o = ~cur_sel_i;
      end else if (!master_ok && backup_ok) begin
         next_sel_o = ~cur_sel_i;
      end
   end
endmodule : rrs_selector

// ==== src/rrs_top.sv ====
// Purpose: Changeover control between two redundant reference units
// Assumes: Single clock, synchronous pins, plain strobe register port
// Notes:   Unit 0 is reference unit one, unit 1 is reference unit two
// Operation
// - One unit drives the whole output set whenever outputs are enabled
// - Status shows current master and own operating state
// - Manual mode bypasses automatics and follows manual unit select
// - Manual mode keeps all outputs enabled regardless of sync
// - Auto mode selects from the two unit sync flags
// - Master loses sync, backup synced: swap master and backup
// - Both units unsynced in auto mode: selection held
// - Manual unit select ignored in auto mode
// - Retention off: outputs disabled while both units unsynced in auto mode
// - Retention on: outputs stay enabled from one unit
// - Front-panel lockout disables front-panel controls
// - Remote lockout disables remote changeover control
// - Function switch off: changeover role; on: network role
// - Priority master enable fixes preferred unit by select switch
// - Retention on, first-sync off: one unit always enabled
// - Retention on, first-sync on: unit enabled after first sync
`timescale 1ns/100ps
module rrs_top (
   input  wire logic              clk_sys_i,
   input  wire logic              rstn_i,
   input  wire logic              sync_a_i,
   input  wire logic              sync_b_i,
   input  wire rrs_pkg::rrs_sig_t sig_a_i,
   input  wire rrs_pkg::rrs_sig_t sig_b_i,
   input  wire logic              fp_auto_i,
   input  wire logic              fp_unit_i,
   input  wire rrs_pkg::rrs_cfg_t cfg_i,
   input  wire logic [3:0]        addr_i,
   input  wire logic [7:0]        wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output rrs_pkg::rrs_sig_t      sig_o,
   output logic                   out_en_o,
   output logic                   master_o,
   output logic [1:0]             state_o,
   output logic                   lan_mode_o,
   output logic [7:0]             rdata_o,
   output logic                   irq_o
);
   // ------------------------------------------------------------
   // Synchronisers
   // ------------------------------------------------------------
   logic sa;
   logic sb;

   rrs_sync2 u_sync_a (
      .clk_sys_i (clk_sys_i),
      .rstn_i    (rstn_i),
      .d_i       (sync_a_i),
      .q_o       (sa)
   );

   rrs_sync2 u_sync_b (
      .clk_sys_i (clk_sys_i),
      .rstn_i    (rstn_i),
      .d_i       (sync_b_i),
      .q_o       (sb)
   );

   // ------------------------------------------------------------
   // Remote control register
   // ------------------------------------------------------------
   logic [1:0] ctrl;
   logic       rem_wr;

   assign rem_wr = wr_i && !cfg_i.rem_lock && !cfg_i.lan_func;

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i)
         ctrl <= rrs_pkg::RRS_CTRL_RST;
      else if (rem_wr && addr_i == rrs_pkg::RRS_OFF_CTRL)
         ctrl <= wdata_i[1:0];
   end

   // ------------------------------------------------------------
   // Mode source
   // ------------------------------------------------------------
   logic auto_mode;
   logic man_unit;

   always_comb begin
      if (!cfg_i.fp_lock) begin
         auto_mode = fp_auto_i;
         man_unit  = fp_unit_i;
      end else if (!cfg_i.rem_lock) begin
         auto_mode = ctrl[rrs_pkg::RRS_CTRL_AUTO];
         man_unit  = ctrl[rrs_pkg::RRS_CTRL_UNIT];
      end else begin
         auto_mode = 1'b1;
         man_unit  = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Selection
   // ------------------------------------------------------------
   logic sel;
   logic next_sel;

   rrs_selector u_sel (
      .auto_i        (auto_mode),
      .manual_unit_i (man_unit),
      .sync_a_i      (sa),
      .sync_b_i      (sb),
      .cur_sel_i     (sel),
      .cfg_i         (cfg_i),
      .next_sel_o    (next_sel)
   );

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i)
         sel <= 1'b0;
      else if (!cfg_i.lan_func)
         sel <= next_sel;
   end

   // ------------------------------------------------------------
   // First sync tracking
   // ------------------------------------------------------------
   logic seen_a;
   logic seen_b;

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         seen_a <= 1'b0;
         seen_b <= 1'b0;
      end else begin
         seen_a <= seen_a | sa;
         seen_b <= seen_b | sb;
      end
   end

   // ------------------------------------------------------------
   // Output gating
   // ------------------------------------------------------------
   logic next_en;
   logic any_sync;
   logic sel_seen;

   always_comb begin
      any_sync = sa | sb;
      sel_seen = next_sel ? seen_b : seen_a;
      if (cfg_i.lan_func)
         next_en = 1'b0;
      else if (!auto_mode)
         next_en = 1'b1;
      else if (any_sync)
         next_en = 1'b1;
      else if (!cfg_i.keep)
         next_en = 1'b0;
      else if (cfg_i.first_sync)
         next_en = sel_seen;
      else
         next_en = 1'b1;
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         out_en_o <= 1'b0;
         sig_o    <= '0;
      end else begin
         out_en_o <= next_en;
         sig_o    <= next_en ? (next_sel ? sig_b_i : sig_a_i) : '0;
      end
   end

   // ------------------------------------------------------------
   // Status
   // ------------------------------------------------------------
   rrs_pkg::rrs_state_t next_state;

   always_comb begin
      if (cfg_i.lan_func)
         next_state = rrs_pkg::RRS_ST_IDLE;
      else if (!auto_mode)
         next_state = rrs_pkg::RRS_ST_MANUAL;
      else if (!any_sync)
         next_state = rrs_pkg::RRS_ST_HOLD;
      else
         next_state = rrs_pkg::RRS_ST_AUTO;
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         master_o   <= 1'b0;
         state_o    <= 2'h0;
         lan_mode_o <= 1'b0;
      end else begin
         master_o   <= next_sel;
         state_o    <= next_state;
         lan_mode_o <= cfg_i.lan_func;
      end
   end

   // ------------------------------------------------------------
   // Interrupts
   // ------------------------------------------------------------
   logic [2:0] irq_st;
   logic [2:0] irq_mask;
   logic [2:0] ev;
   logic       both_lost_q;

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i)
         both_lost_q <= 1'b0;
      else
         both_lost_q <= !any_sync;
   end

   always_comb begin
      ev = '0;
      ev[rrs_pkg::RRS_IRQ_SWITCH]   = next_sel != sel;
      ev[rrs_pkg::RRS_IRQ_BOTHLOST] = !any_sync && !both_lost_q;
      ev[rrs_pkg::RRS_IRQ_REGAIN]   = any_sync && both_lost_q;
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_st   <= rrs_pkg::RRS_IRQ_RST;
         irq_mask <= rrs_pkg::RRS_IRQ_RST;
      end else begin
         if (wr_i && addr_i == rrs_pkg::RRS_OFF_IRQ)
            irq_st <= (irq_st & ~wdata_i[2:0]) | ev;
         else
            irq_st <= irq_st | ev;
         if (wr_i && addr_i == rrs_pkg::RRS_OFF_MASK)
            irq_mask <= wdata_i[2:0];
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i)
         irq_o <= 1'b0;
      else
         irq_o <= |(((irq_st | ev) & ~((wr_i && addr_i == rrs_pkg::RRS_OFF_IRQ)
                   ? wdata_i[2:0] & ~ev : 3'h0)) & irq_mask);
   end

   // ------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i)
         rdata_o <= 8'h00;
      else if (rd_i) begin
         unique case (addr_i)
            rrs_pkg::RRS_OFF_CTRL:   rdata_o <= {6'h00, ctrl};
            rrs_pkg::RRS_OFF_CFG:    rdata_o <= {1'b0, cfg_i};
            rrs_pkg::RRS_OFF_STATUS: rdata_o <= {1'b0, seen_b, seen_a, sb, sa,
                                                 out_en_o, state_o[1], sel};
            rrs_pkg::RRS_OFF_IRQ:    rdata_o <= {5'h00, irq_st};
            rrs_pkg::RRS_OFF_MASK:   rdata_o <= {5'h00, irq_mask};
            default:                 rdata_o <= 8'h00;
         endcase
      end else
         rdata_o <= 8'h00;
   end

endmodule : rrs_top

// ==== sim/rrs_top_assertions.sv ====
// Purpose: Port-level checks of the reference changeover switch
// Assumes: Front panel decides the mode unless locked out
// Notes:   Sync flags take a few cycles to reach the outputs
`timescale 1ns/100ps
module rrs_top_assertions (
   input  wire logic              clk_sys_i,
   input  wire logic              rstn_i,
   input  wire logic              sync_a_i,
   input  wire logic              sync_b_i,
   input  wire rrs_pkg::rrs_sig_t sig_a_i,
   input  wire rrs_pkg::rrs_sig_t sig_b_i,
   input  wire logic              fp_auto_i,
   input  wire logic              fp_unit_i,
   input  wire rrs_pkg::rrs_cfg_t cfg_i,
   input  wire rrs_pkg::rrs_sig_t sig_o,
   input  wire logic              out_en_o,
   input  wire logic              master_o,
   input  wire logic [1:0]        state_o,
   input  wire logic              lan_mode_o,
   input  wire logic              irq_o
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   wire logic au   = fp_auto_i && !cfg_i.fp_lock && !cfg_i.lan_func;
   wire logic lost = !sync_a_i && !sync_b_i;

   AST_ROUTE: assert property (out_en_o |-> sig_o == (master_o ? sig_b_i : sig_a_i))
      else $error("Set not from master");
   AST_MUTE: assert property (!out_en_o |-> sig_o == 4'h0)
      else $error("Disabled set not zero");
   AST_SWAP: assert property (au && state_o == 2'h1 && !cfg_i.prio_en && !master_o &&
      $fell(sync_a_i) && sync_b_i |-> ##[1:3] master_o) else $error("No swap");
   AST_HOLD: assert property ((au && lost)[*5] |-> $stable(master_o))
      else $error("Selection moved");
   AST_MANUAL: assert property ((!fp_auto_i && !cfg_i.fp_lock && !cfg_i.lan_func &&
      $stable(fp_unit_i))[*5] |-> master_o == fp_unit_i) else $error("Manual lost");
   AST_MAN_EN: assert property (state_o == 2'h2 [*2] |-> out_en_o)
      else $error("Manual output off");
   AST_NOKEEP: assert property ((au && lost && !cfg_i.keep)[*5] |-> !out_en_o)
      else $error("Output not disabled");
   AST_KEEP: assert property ((au && lost && cfg_i.keep && !cfg_i.first_sync)[*5]
      |-> out_en_o) else $error("Output not kept");
   AST_PRIO: assert property ((au && cfg_i.prio_en && $stable(cfg_i) && !lost &&
      sync_a_i && sync_b_i)[*5] |-> master_o == !cfg_i.prio_sel) else $error("Prio");
   AST_LAN: assert property (cfg_i.lan_func [*3] |-> lan_mode_o && !out_en_o)
      else $error("Network role wrong");

   cover property ($rose(master_o));
   cover property (state_o == 2'h3);
   cover property ($rose(irq_o));
endmodule : rrs_top_assertions

bind rrs_top rrs_top_assertions u_rrs_chk (.clk_sys_i, .rstn_i, .sync_a_i, .sync_b_i,
   .sig_a_i, .sig_b_i, .fp_auto_i, .fp_unit_i, .cfg_i, .sig_o, .out_en_o, .master_o,
   .state_o, .lan_mode_o, .irq_o);

// ==== sim/rrs_ref_pair.sv ====
// Purpose: Two reference units feeding sync flags and output sets
// Assumes: Bench commands the lock state of each unit
// Notes:   Fixed distinct patterns expose any mixing of sets
`timescale 1ns/100ps
module rrs_ref_pair (
   input  wire logic        lock_a_i,
   input  wire logic        lock_b_i,
   output logic              sync_a_o,
   output logic              sync_b_o,
   output rrs_pkg::rrs_sig_t sig_a_o,
   output rrs_pkg::rrs_sig_t sig_b_o
);
   assign sync_a_o = lock_a_i;
   assign sync_b_o = lock_b_i;
   assign sig_a_o  = 4'h5;
   assign sig_b_o  = 4'ha;
endmodule : rrs_ref_pair

// ==== sim/tb_redundant_reference_switch.sv ====
// Purpose: Self-checking bench for the reference changeover switch
// Assumes: Read data stands the cycle after the read strobe
// Notes:   Unit one sends pattern 5, unit two pattern a
`timescale 1ns/100ps
module tb_redundant_reference_switch;
   typedef struct packed {
      logic       au, un, la, lb, m, en;
      logic [1:0] st;
   } rrs_row_t;
   logic              clk_sys_i, rstn_i, lock_a_i, lock_b_i, sync_a_i, sync_b_i;
   logic              fp_auto_i, fp_unit_i, wr_i, rd_i, out_en_o, master_o, lan_mode_o, irq_o;
   logic [3:0]        addr_i;
   logic [7:0]        wdata_i, rdata_o;
   logic [1:0]        state_o;
   rrs_pkg::rrs_sig_t sig_a_i, sig_b_i, sig_o;
   rrs_pkg::rrs_cfg_t cfg_i;
   int                errors, checks_done;
   rrs_row_t          rows [8] = '{8'hb5, 8'h9d, 8'hbd, 8'he5, 8'hc3, 8'h4e, 8'h06, 8'hb5};

   rrs_ref_pair PART (.lock_a_i, .lock_b_i, .sync_a_o(sync_a_i), .sync_b_o(sync_b_i),
      .sig_a_o(sig_a_i), .sig_b_o(sig_b_i));
   rrs_top DUT (.clk_sys_i, .rstn_i, .sync_a_i, .sync_b_i, .sig_a_i, .sig_b_i, .fp_auto_i,
      .fp_unit_i, .cfg_i, .addr_i, .wdata_i, .wr_i, .rd_i, .sig_o, .out_en_o, .master_o,
      .state_o, .lan_mode_o, .rdata_o, .irq_o);

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask : step
   task automatic expect_out(input logic m, input logic en, input logic [1:0] st);
      step(6);
      check({6'h00, master_o, out_en_o}, {6'h00, m, en});
      check({6'h00, state_o}, {6'h00, st});
      check({4'h0, sig_o}, {4'h0, (en ? (m ? 4'ha : 4'h5) : 4'h0)});
   endtask : expect_out
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1 check(rdata_o, exp);
   endtask : rd_reg
   task automatic complete_run;
      $display("Checks %0d, errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : complete_run

   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      #100000;
      errors++;
      complete_run();
   end
   initial begin
      rstn_i    = 1'b0;
      lock_a_i  = 1'b1;
      lock_b_i  = 1'b1;
      fp_auto_i = 1'b1;
      fp_unit_i = 1'b0;
      wr_i      = 1'b0;
      rd_i      = 1'b0;
      addr_i    = 4'h0;
      wdata_i   = 8'h00;
      cfg_i     = '0;
      repeat (11) @(posedge clk_sys_i);
      #1 check({2'h0, master_o, out_en_o, irq_o, lan_mode_o, state_o}, 8'h00);
      @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      rd_reg(rrs_pkg::RRS_OFF_CTRL, 8'h01);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys_i);
         fp_auto_i <= rows[i].au;
         fp_unit_i <= rows[i].un;
         lock_a_i  <= rows[i].la;
         lock_b_i  <= rows[i].lb;
         expect_out(rows[i].m, rows[i].en, rows[i].st);
      end
      @(posedge clk_sys_i);
      cfg_i.keep <= 1'b1;
      lock_a_i   <= 1'b0;
      lock_b_i   <= 1'b0;
      expect_out(1'b0, 1'b1, 2'h3);
      @(posedge clk_sys_i);
      cfg_i.keep    <= 1'b0;
      cfg_i.prio_en <= 1'b1;
      lock_a_i      <= 1'b1;
      lock_b_i      <= 1'b1;
      expect_out(1'b1, 1'b1, 2'h1);
      @(posedge clk_sys_i);
      cfg_i.prio_sel <= 1'b1;
      expect_out(1'b0, 1'b1, 2'h1);
      @(posedge clk_sys_i);
      cfg_i <= '0;
      wr_reg(rrs_pkg::RRS_OFF_MASK, 8'h07);
      step(2);
      check({7'h00, irq_o}, 8'h01);
      wr_reg(rrs_pkg::RRS_OFF_IRQ, 8'h07);
      step(2);
      check({7'h00, irq_o}, 8'h00);
      wr_reg(rrs_pkg::RRS_OFF_MASK, 8'h00);
      @(posedge clk_sys_i);
      lock_a_i <= 1'b0;
      expect_out(1'b1, 1'b1, 2'h1);
      check({7'h00, irq_o}, 8'h00);
      rd_reg(rrs_pkg::RRS_OFF_IRQ, 8'h01);
      wr_reg(rrs_pkg::RRS_OFF_MASK, 8'h01);
      step(2);
      check({7'h00, irq_o}, 8'h01);
      @(posedge clk_sys_i);
      lock_a_i      <= 1'b1;
      cfg_i.fp_lock <= 1'b1;
      wr_reg(rrs_pkg::RRS_OFF_CTRL, 8'h00);
      expect_out(1'b0, 1'b1, 2'h2);
      rd_reg(rrs_pkg::RRS_OFF_CFG, 8'h20);
      @(posedge clk_sys_i);
      cfg_i.rem_lock <= 1'b1;
      wr_reg(rrs_pkg::RRS_OFF_CTRL, 8'h03);
      step(6);
      check({6'h00, state_o}, 8'h01);
      rd_reg(rrs_pkg::RRS_OFF_CTRL, 8'h00);
      rd_reg(4'hf, 8'h00);
      @(posedge clk_sys_i);
      cfg_i            <= '0;
      cfg_i.keep       <= 1'b1;
      cfg_i.first_sync <= 1'b1;
      lock_a_i         <= 1'b0;
      lock_b_i         <= 1'b0;
      rstn_i           <= 1'b0;
      step(2);
      check({2'h0, master_o, out_en_o, irq_o, lan_mode_o, state_o}, 8'h00);
      @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      expect_out(1'b0, 1'b0, 2'h3);
      @(posedge clk_sys_i);
      lock_a_i <= 1'b1;
      expect_out(1'b0, 1'b1, 2'h1);
      rd_reg(rrs_pkg::RRS_OFF_IRQ, 8'h06);
      rd_reg(rrs_pkg::RRS_OFF_STATUS, 8'h2c);
      @(posedge clk_sys_i);
      lock_a_i <= 1'b0;
      expect_out(1'b0, 1'b1, 2'h3);
      @(posedge clk_sys_i);
      cfg_i.lan_func <= 1'b1;
      step(6);
      check({4'h0, lan_mode_o, out_en_o, state_o}, 8'h08);
      complete_run();
   end
endmodule : tb_redundant_reference_switch
